/* File: core/dsp_alu_accumulator_shift_logic.sv */
// arithmetic datapath: sum register, save buffer, scaling shifter,
// post-store shifter, normalisation, min/max and bitwise memory unit
// assumes decode issues commands on i_clk_sys and holds data valid with them
//
// Functional notes
// - 32-bit unit, 16-bit operands, boolean and arithmetic
// - sum is one operand; other is selectable
// - results written back into sum register
// - store halves with left shift 0 to 7
// - shifted store leaves sum register unchanged
// - upper store fills from lower half top
// - lower store fills vacated bits with zeros
// - normalisation left-shifts sum register
// - variable shift uses four low temp bits
// - single-cycle right shift by 1 to 16
// - save buffer captures sum, usable as operand
// - min/max writes both; carry set when true
// - scaling shifter 16 in, 32 out, 0-16
// - scaling count from instruction or temp register
// - zero-fill low bits; sign mode sets top
// - bitwise unit leaves sum register untouched
// - set, clear, test or toggle many bits
// - operations complete in one cycle
`timescale 1ns/1ps
`default_nettype none

module dsp_alu_accumulator_shift_logic
    import alu_pkg::*;
#(
    parameter int DATA_W = 16,  // data word width
    parameter int ACC_W  = 32   // sum register width
) (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // commands from decode
    input  wire alu_cmd_t    i_cmd,
    input  wire store_cmd_t  i_store,
    input  wire bit_cmd_t    i_bit,
    // operand sources
    input  wire logic [15:0] i_data_word,      // data bus or immediate
    input  wire logic [31:0] i_product_holding,
    input  wire logic [15:0] i_shift_count_temp,
    input  wire logic        i_sign_extend_flag,
    // results
    output logic [31:0]      o_sum_register,
    output logic [31:0]      o_save_buffer,
    output logic             o_carry,
    output logic [15:0]      o_store_data,
    output logic             o_store_valid,
    output logic [15:0]      o_bit_data,
    output logic             o_bit_write,
    output logic             o_bit_tc,
    output logic             o_bit_valid
);

    // ==========================================================
    // elaboration checks
    // ==========================================================
    if (DATA_W != WORD_W || ACC_W != SUM_W) begin : g_chk
        $error("datapath widths must be 16 and 32");
    end

    // ==========================================================
    // state
    // ==========================================================
    logic [31:0] sum_q;         // sum register
    logic [31:0] sum_d;         // next sum
    logic [31:0] save_q;        // save buffer
    logic [31:0] save_d;        // next save buffer
    logic        carry_q;       // carry bit
    logic        carry_d;       // next carry
    logic [15:0] store_q;       // store data register
    logic        store_v_q;     // store strobe register
    logic [15:0] bit_q;         // bitwise result register
    logic        bit_w_q;       // bitwise write strobe
    logic        bit_tc_q;      // bitwise test result
    logic        bit_v_q;       // bitwise done strobe

    // ==========================================================
    // scaling shifter
    // ==========================================================
    logic [4:0]  scale_n;       // effective count
    logic [31:0] scale_in;      // extended input
    logic [31:0] scale_out;     // shifter output

    // count from instruction field or from temp low bits
    always_comb begin
        if (i_cmd.use_temp) begin
            scale_n = {1'b0, i_shift_count_temp[TCNT_W-1:0]};
        end else if (i_cmd.scale_cnt > SCALE_MAX) begin
            scale_n = SCALE_MAX;   // clamp out-of-range field
        end else begin
            scale_n = i_cmd.scale_cnt;
        end
    end

    // extension by sign mode, zero fill at the bottom
    always_comb begin
        if (i_sign_extend_flag) begin
            scale_in = {{16{i_data_word[15]}}, i_data_word};
        end else begin
            scale_in = {16'h0000, i_data_word};
        end
        scale_out = scale_in << scale_n;
    end

    // ==========================================================
    // operand select and arithmetic
    // ==========================================================
    logic [31:0] opnd;          // second operand
    logic [32:0] add_r;         // sum with carry out
    logic [32:0] sub_r;         // difference with borrow
    logic [31:0] rsh_r;         // right shifted sum
    logic [4:0]  rsh_n;         // clamped right count
    logic [31:0] leading_bit_align_op_r;        // normalised sum
    logic        leading_bit_align_op_go;       // top two bits equal and sum nonzero
    logic        save_lt;       // save buffer below sum

    // other operand from scaler, product or save buffer
    always_comb begin
        case (i_cmd.src)
            SRC_PRODUCT: opnd = i_product_holding;
            SRC_SAVE:    opnd = save_q;
            default:     opnd = scale_out;
        endcase
    end

    // arithmetic on sum and operand
    always_comb begin
        add_r   = {1'b0, sum_q} + {1'b0, opnd};
        sub_r   = {1'b0, sum_q} - {1'b0, opnd};
        rsh_n   = (i_cmd.rsh_cnt == 5'h00) ? 5'h01 :
                  (i_cmd.rsh_cnt > RSH_MAX) ? RSH_MAX : i_cmd.rsh_cnt;
        rsh_r   = i_sign_extend_flag ?
                  32'($signed(sum_q) >>> rsh_n) :
                  (sum_q >> rsh_n);
        // one normalisation step when the top bits carry no information
        leading_bit_align_op_go = (sum_q != SUM_RST) &&
                  ((sum_q & LEADING_BIT_ALIGN_OP_TOP_MASK) == SUM_RST ||
                   (sum_q & LEADING_BIT_ALIGN_OP_TOP_MASK) == LEADING_BIT_ALIGN_OP_TOP_MASK);
        leading_bit_align_op_r  = leading_bit_align_op_go ? (sum_q << 1) : sum_q;
        save_lt = $signed(save_q) < $signed(sum_q);
    end

    // next sum, save buffer and carry
    always_comb begin
        sum_d   = sum_q;
        save_d  = save_q;
        carry_d = carry_q;
        if (i_cmd.valid) begin
            case (i_cmd.op)
                OP_LOAD:   sum_d = opnd;
                OP_ADD: begin
                    sum_d   = add_r[31:0];
                    carry_d = add_r[32];
                end
                OP_SUB: begin
                    sum_d   = sub_r[31:0];
                    carry_d = ~sub_r[32];
                end
                OP_AND:    sum_d = sum_q & opnd;
                OP_OR:     sum_d = sum_q | opnd;
                OP_XOR:    sum_d = sum_q ^ opnd;
                OP_RSHIFT: sum_d = rsh_r;
                OP_LEADING_BIT_ALIGN_OP:   sum_d = leading_bit_align_op_r;
                OP_SAVE:   save_d = sum_q;
                OP_MIN: begin
                    // smaller value into both, carry when buffer smaller
                    sum_d   = save_lt ? save_q : sum_q;
                    save_d  = save_lt ? save_q : sum_q;
                    carry_d = save_lt;
                end
                OP_MAX: begin
                    sum_d   = (!save_lt && save_q != sum_q) ?
                              save_q : sum_q;
                    save_d  = (!save_lt && save_q != sum_q) ?
                              save_q : sum_q;
                    carry_d = !save_lt && save_q != sum_q;
                end
                default: ;  // no-op holds everything
            endcase
        end
    end

    // registers of the sum unit, one cycle per op
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sum_q   <= SUM_RST;
            save_q  <= SUM_RST;
            carry_q <= 1'b0;
        end else begin
            sum_q   <= sum_d;
            save_q  <= save_d;
            carry_q <= carry_d;
        end
    end

    // ==========================================================
    // post-store shifter
    // ==========================================================
    logic [47:0] post_w;        // upper half with lower beneath

    // shift on the way out; sum register is only read
    always_comb begin
        post_w = {sum_q[31:16], sum_q[15:0], 16'h0000} << i_store.shift;
    end

    // store data register
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            store_q   <= WORD_RST;
            store_v_q <= 1'b0;
        end else begin
            store_v_q <= i_store.valid;
            if (i_store.valid) begin
                if (i_store.upper) begin
                    store_q <= post_w[47:32];
                end else begin
                    store_q <= post_w[31:16];
                end
            end
        end
    end

    // ==========================================================
    // bitwise memory unit
    // ==========================================================
    logic [15:0] bit_r;         // modified word
    logic        bit_wr;        // result is written back

    // operate on memory word only, never the sum register
    always_comb begin
        bit_wr = 1'b1;
        case (i_bit.op)
            BIT_SET:    bit_r = i_bit.word | i_bit.mask;
            BIT_CLEAR:  bit_r = i_bit.word & ~i_bit.mask;
            BIT_TOGGLE: bit_r = i_bit.word ^ i_bit.mask;
            default: begin
                bit_r  = i_bit.word;
                bit_wr = 1'b0;
            end
        endcase
    end

    // result registers of the bitwise unit
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            bit_q    <= WORD_RST;
            bit_w_q  <= 1'b0;
            bit_tc_q <= 1'b0;
            bit_v_q  <= 1'b0;
        end else begin
            bit_v_q <= i_bit.valid;
            bit_w_q <= i_bit.valid && bit_wr;
            if (i_bit.valid) begin
                bit_q    <= bit_r;
                bit_tc_q <= (i_bit.word & i_bit.mask) == i_bit.mask;
            end
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign o_sum_register = sum_q;
    assign o_save_buffer  = save_q;
    assign o_carry        = carry_q;
    assign o_store_data   = store_q;
    assign o_store_valid  = store_v_q;
    assign o_bit_data     = bit_q;
    assign o_bit_write    = bit_w_q;
    assign o_bit_tc       = bit_tc_q;
    assign o_bit_valid    = bit_v_q;

endmodule : dsp_alu_accumulator_shift_logic

`default_nettype wire

/* File: core/alu_pkg.sv */
// package for the arithmetic datapath: opcodes, field widths, carriers
// assumes a single core clock and a decoder that issues one op per cycle
package alu_pkg;

    // =========================================================
    // widths
    // =========================================================
    localparam int WORD_W  = 16;            // data bus word
    localparam int SUM_W   = 32;            // sum register width
    localparam int SCNT_W  = 5;             // scaling shift count 0..16
    localparam int PCNT_W  = 3;             // post-store shift 0..7
    localparam int TCNT_W  = 4;             // low bits of shift-count temp
    localparam logic [4:0] SCALE_MAX = 5'h10; // largest scaling shift
    localparam logic [4:0] RSH_MAX   = 5'h10; // largest right shift
    localparam logic [31:0] SUM_RST  = 32'h0000_0000;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [31:0] LEADING_BIT_ALIGN_OP_TOP_MASK = 32'hC000_0000;

    // =========================================================
    // operation codes of the sum-register unit
    // =========================================================
    typedef enum logic [3:0] {
        OP_NOP     = 4'h0,  // hold
        OP_LOAD    = 4'h1,  // sum <= operand
        OP_ADD     = 4'h2,  // sum <= sum + operand
        OP_SUB     = 4'h3,  // sum <= sum - operand
        OP_AND     = 4'h4,  // boolean and
        OP_OR      = 4'h5,  // boolean or
        OP_XOR     = 4'h6,  // boolean xor
        OP_RSHIFT  = 4'h7,  // right shift by 1..16
        OP_LEADING_BIT_ALIGN_OP    = 4'h8,  // leading_bit_align_op
        OP_SAVE    = 4'h9,  // save_buffer <= sum
        OP_MIN     = 4'hA,  // min_select_op
        OP_MAX     = 4'hB   // max_select_op
    } alu_op_t;

    // second operand source
    typedef enum logic [1:0] {
        SRC_SCALE   = 2'h0, // scaling shifter output
        SRC_PRODUCT = 2'h1, // product_holding
        SRC_SAVE    = 2'h2  // save_buffer
    } alu_src_t;

    // bitwise memory unit operations
    typedef enum logic [1:0] {
        BIT_SET    = 2'h0,
        BIT_CLEAR  = 2'h1,
        BIT_TOGGLE = 2'h2,
        BIT_TEST   = 2'h3
    } bit_op_t;

    // command from decode to the sum-register unit
    typedef struct packed {
        logic       valid;      // one-cycle issue
        alu_op_t    op;         // operation
        alu_src_t   src;        // operand source
        logic       use_temp;   // scaling count from shift-count temp
        logic [4:0] scale_cnt;  // immediate scaling count
        logic [4:0] rsh_cnt;    // right shift amount 1..16
    } alu_cmd_t;

    // command for a shifted store
    typedef struct packed {
        logic       valid;      // one-cycle store strobe
        logic       upper;      // 1 = upper half, 0 = lower half
        logic [2:0] shift;      // left shift 0..7
    } store_cmd_t;

    // command for the bitwise memory unit
    typedef struct packed {
        logic        valid;     // one-cycle strobe
        bit_op_t     op;        // operation
        logic [15:0] mask;      // bit mask
        logic [15:0] word;      // memory word read
    } bit_cmd_t;

endpackage : alu_pkg

/* File: testbench/alu_path_monitor.sv */
// checker on the ports of the arithmetic datapath
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module alu_path_monitor
    import alu_pkg::*;
(
    // clock and reset
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    // commands and operands
    input wire alu_cmd_t    i_cmd,
    input wire store_cmd_t  i_store,
    input wire bit_cmd_t    i_bit,
    input wire logic [15:0] i_data_word,
    input wire logic [31:0] i_product_holding,
    input wire logic [15:0] i_shift_count_temp,
    input wire logic        i_sign_extend_flag,
    // results
    input wire logic [31:0] o_sum_register,
    input wire logic [31:0] o_save_buffer,
    input wire logic        o_carry,
    input wire logic [15:0] o_store_data,
    input wire logic        o_store_valid,
    input wire logic [15:0] o_bit_data,
    input wire logic        o_bit_write,
    input wire logic        o_bit_tc,
    input wire logic        o_bit_valid
);
    // =========================================================
    // clocking and sequences
    // =========================================================
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // a store or bit op with no sum command beside it
    sequence s_side_only;
        (i_store.valid || i_bit.valid) && !i_cmd.valid;
    endsequence
    // a sum command on the product source
    sequence s_prod(alu_op_t k);
        i_cmd.valid && i_cmd.op == k && i_cmd.src == SRC_PRODUCT;
    endsequence
    // =========================================================
    // assertions
    // =========================================================
    chk_side_keeps_sum: assert property (
        s_side_only |=> $stable(o_sum_register))
        else $error("sum changed by store or bit op");
    chk_upper_store_fill: assert property (
        i_store.valid && i_store.upper |=> o_store_valid && o_store_data ==
        16'(($past(o_sum_register) << $past(i_store.shift)) >> 16))
        else $error("upper store data wrong");
    chk_lower_store_zero: assert property (
        i_store.valid && !i_store.upper |=> o_store_valid && o_store_data ==
        16'($past(o_sum_register) << $past(i_store.shift)))
        else $error("lower store data wrong");
    chk_store_one_pulse: assert property (
        !i_store.valid |=> !o_store_valid)
        else $error("store strobe without request");
    chk_load_product: assert property (
        s_prod(OP_LOAD) |=> o_sum_register == $past(i_product_holding))
        else $error("product load wrong");
    chk_add_carry_out: assert property (
        s_prod(OP_ADD) |=> {o_carry, o_sum_register} ==
        {1'b0, $past(o_sum_register)} + {1'b0, $past(i_product_holding)})
        else $error("add sum or carry wrong");
    chk_save_capture: assert property (
        i_cmd.valid && i_cmd.op == OP_SAVE
        |=> o_save_buffer == $past(o_sum_register))
        else $error("save buffer capture wrong");
    chk_minmax_both: assert property (
        i_cmd.valid && (i_cmd.op == OP_MIN || i_cmd.op == OP_MAX)
        |=> o_sum_register == o_save_buffer)
        else $error("min or max left registers apart");
    chk_bit_set_write: assert property (
        i_bit.valid && i_bit.op == BIT_SET |=> o_bit_valid && o_bit_write
        && o_bit_data == ($past(i_bit.word) | $past(i_bit.mask)))
        else $error("bit set result wrong");
endmodule : alu_path_monitor
bind dsp_alu_accumulator_shift_logic alu_path_monitor mon (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cmd(i_cmd),
    .i_store(i_store), .i_bit(i_bit), .i_data_word(i_data_word),
    .i_product_holding(i_product_holding),
    .i_shift_count_temp(i_shift_count_temp),
    .i_sign_extend_flag(i_sign_extend_flag),
    .o_sum_register(o_sum_register), .o_save_buffer(o_save_buffer),
    .o_carry(o_carry), .o_store_data(o_store_data),
    .o_store_valid(o_store_valid), .o_bit_data(o_bit_data),
    .o_bit_write(o_bit_write), .o_bit_tc(o_bit_tc),
    .o_bit_valid(o_bit_valid));
`default_nettype wire

/* File: testbench/data_word_model.sv */
// data memory word on the far side of the store and bit paths
// assumes one clock; write strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module data_word_model (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // write paths from the datapath
    input  wire logic        i_store_valid,
    input  wire logic [15:0] i_store_data,
    input  wire logic        i_bit_write,
    input  wire logic [15:0] i_bit_data,
    // memory word and count of writes
    output logic      [15:0] o_word,
    output logic      [7:0]  o_writes
);
    // capture one write per cycle, store over bit; a stuck strobe shows as extra counts
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_word <= 16'h0000;
            o_writes <= 8'h00;
        end else if (i_store_valid || i_bit_write) begin
            o_word <= i_store_valid ? i_store_data : i_bit_data;
            o_writes <= o_writes + 8'h01;
        end
    end
endmodule : data_word_model
`default_nettype wire

/* File: testbench/dsp_alu_accumulator_shift_logic_bench.sv */
// self-checking bench for the arithmetic datapath
// assumes a 40 MHz clock and results one cycle after a request
`timescale 1ns/1ps
`default_nettype none
module dsp_alu_accumulator_shift_logic_bench;
    import alu_pkg::*;
    // =========================================================
    // signals
    // =========================================================
    logic clk, rst, sx, sx_nx, ut, svld, bwr, btc, bvld, cy;
    alu_cmd_t cmd;
    store_cmd_t st;
    bit_cmd_t bt;
    logic [15:0] dw, tmp, tmp_nx, sd, bd, mem, ex;
    logic [31:0] prod, sum, sav;
    logic [7:0] wr;
    int err_count, check_count;
    logic [31:0] bx [3] = '{32'hF000_0034, 32'hFFF0_12FF, 32'h0FF0_12CB};
    logic [15:0] bb [3] = '{16'hAFF0, 16'hA000, 16'hAA00};
    dsp_alu_accumulator_shift_logic DUT (.i_clk_sys(clk), .i_rst(rst),
        .i_cmd(cmd), .i_store(st), .i_bit(bt), .i_data_word(dw),
        .i_product_holding(prod), .i_shift_count_temp(tmp),
        .i_sign_extend_flag(sx), .o_sum_register(sum),
        .o_save_buffer(sav), .o_carry(cy), .o_store_data(sd),
        .o_store_valid(svld), .o_bit_data(bd), .o_bit_write(bwr),
        .o_bit_tc(btc), .o_bit_valid(bvld));
    data_word_model mem_i (.i_clk_sys(clk), .i_rst(rst),
        .i_store_valid(svld), .i_store_data(sd), .i_bit_write(bwr),
        .i_bit_data(bd), .o_word(mem), .o_writes(wr));
    // =========================================================
    // tasks
    // =========================================================
    task automatic check(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    // one request, taken at the next edge, outputs read after it
    task automatic issue(input alu_cmd_t c, input store_cmd_t s,
                         input bit_cmd_t b, input logic [15:0] d,
                         input logic [31:0] p);
        @(posedge clk);
        cmd <= c; st <= s; bt <= b; dw <= d; prod <= p;
        tmp <= tmp_nx; sx <= sx_nx;
        @(posedge clk);
        cmd <= '0; st <= '0; bt <= '0;
        #1;
    endtask : issue
    task automatic alu(input alu_op_t op, input alu_src_t src,
                       input logic [4:0] n, input logic [31:0] p,
                       input logic [15:0] d = 16'h0000);
        issue('{1'b1, op, src, ut, n, n}, '0, '0, d, p);
    endtask : alu
    // expected scaling shifter output
    function automatic logic [31:0] scl(logic [15:0] d, logic s, int n);
        return (s ? {{16{d[15]}}, d} : {16'h0000, d}) << (n > 16 ? 16 : n);
    endfunction : scl
    // =========================================================
    // clock, watchdog, tests
    // =========================================================
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        end_sim();
    end
    initial begin
        rst = 1'b1; cmd = '0; st = '0; bt = '0; dw = 16'h0000;
        prod = 32'h0; tmp = 16'h0000; tmp_nx = 16'h0000;
        sx = 1'b0; sx_nx = 1'b0; ut = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1 check("sum after reset", sum, 32'h0);
        for (int n = 0; n < 18; n++) begin
            sx_nx = n[0];
            alu(OP_LOAD, SRC_SCALE, 5'(n), 32'h0, 16'h8001);
            check("scaled load", sum, scl(16'h8001, n[0], n));
        end
        ut = 1'b1; tmp_nx = 16'hFFF3; sx_nx = 1'b0;
        alu(OP_LOAD, SRC_SCALE, 5'h10, 32'h0, 16'h0101);
        check("temp count", sum, 32'h0000_0808);
        ut = 1'b0;
        alu(OP_LOAD, SRC_PRODUCT, 5'h00, 32'hFFFF_FFFF);
        alu(OP_ADD, SRC_SCALE, 5'h04, 32'h0, 16'h0001);
        check("add sum", sum, 32'h0000_000F);
        check("add carry", 32'(cy), 32'h1);
        alu(OP_SUB, SRC_PRODUCT, 5'h00, 32'h0000_0010);
        check("sub sum", sum, 32'hFFFF_FFFF);
        check("sub carry", 32'(cy), 32'h0);
        for (int i = 0; i < 3; i++) begin
            alu(OP_LOAD, SRC_PRODUCT, 5'h00, 32'hF0F0_1234);
            alu(alu_op_t'(4'(OP_AND + i)), SRC_PRODUCT, 5'h00, 32'hFF00_00FF);
            check("boolean", sum, bx[i]);
        end
        alu(OP_LOAD, SRC_PRODUCT, 5'h00, 32'h0000_0100);
        alu(OP_SAVE, SRC_PRODUCT, 5'h00, 32'h0);
        alu(OP_LOAD, SRC_PRODUCT, 5'h00, 32'h0000_0023);
        alu(OP_ADD, SRC_SAVE, 5'h00, 32'h0);
        check("save operand", sum, 32'h0000_0123);
        for (int i = 0; i < 4; i++) begin
            sx_nx = (i == 0);
            alu(OP_LOAD, SRC_PRODUCT, 5'h00, 32'h8000_0000);
            alu(OP_RSHIFT, SRC_PRODUCT, 5'(i == 0 ? 16 : i == 1 ? 1 : i == 2
                ? 0 : 20), 32'h0);
            check("right shift", sum, i == 0 ? 32'hFFFF_8000 : i < 3 ?
                32'h4000_0000 : 32'h0000_8000);
        end
        sx_nx = 1'b0;
        alu(OP_LOAD, SRC_PRODUCT, 5'h00, 32'h0000_1000);
        alu(OP_LEADING_BIT_ALIGN_OP, SRC_PRODUCT, 5'h00, 32'h0);
        check("leading_bit_align_op shift", sum, 32'h0000_2000);
        alu(OP_LOAD, SRC_PRODUCT, 5'h00, 32'h4000_0000);
        alu(OP_LEADING_BIT_ALIGN_OP, SRC_PRODUCT, 5'h00, 32'h0);
        check("leading_bit_align_op hold", sum, 32'h4000_0000);
        alu(OP_LOAD, SRC_PRODUCT, 5'h00, 32'h5);
        alu(OP_SAVE, SRC_PRODUCT, 5'h00, 32'h0);
        alu(OP_LOAD, SRC_PRODUCT, 5'h00, 32'h3);
        alu(OP_MAX, SRC_PRODUCT, 5'h00, 32'h0);
        check("max", {sum[15:0], sav[15:0]}, {16'h5, 16'h5});
        check("max carry", 32'(cy), 32'h1);
        alu(OP_LOAD, SRC_PRODUCT, 5'h00, 32'h7);
        alu(OP_MIN, SRC_PRODUCT, 5'h00, 32'h0);
        check("min", {sum[15:0], sav[15:0]}, {16'h5, 16'h5});
        check("min carry", 32'(cy), 32'h1);
        alu(OP_LOAD, SRC_PRODUCT, 5'h00, 32'h9ABC_DEF1);
        for (int s = 0; s < 16; s++) begin
            ex = s[3] ? 16'((32'h9ABC_DEF1 << s[2:0]) >> 16) :
                 16'(32'h9ABC_DEF1 << s[2:0]);
            issue('0, '{1'b1, s[3], 3'(s)}, '0, 16'h0000, 32'h0);
            check("store out", {svld, sd}, {1'b1, ex});
            check("sum after store", sum, 32'h9ABC_DEF1);
            // the word model takes the strobe one edge later
            @(posedge clk) #1;
            check("stored word", mem, ex);
        end
        issue('{1'b1, OP_ADD, SRC_PRODUCT, 1'b0, 5'h0, 5'h0},
              '{1'b1, 1'b1, 3'h0}, '0, 16'h0000, 32'h1);
        check("add beside store", sum, 32'h9ABC_DEF2);
        check("store before add", sd, 16'h9ABC);
        @(posedge clk) #1;
        check("stored before add", mem, 16'h9ABC);
        for (int i = 0; i < 4; i++) begin
            issue('0, '0, '{1'b1, bit_op_t'(i), 16'h0FF0, 16'hA5F0},
                  16'h0000, 32'h0);
            check("bit flags", {bvld, bwr, btc}, {1'b1, i != 3, 1'b0});
            check("sum after bit op", sum, 32'h9ABC_DEF2);
            if (i < 3) check("bit data", bd, bb[i]);
            // written word lands in the model one edge after the pulse
            @(posedge clk) #1;
            if (i < 3) check("bit word", mem, bb[i]);
        end
        issue('0, '0, '{1'b1, BIT_TEST, 16'h0FF0, 16'hFFF0}, 16'h0, 32'h0);
        check("bit test", 32'(btc), 32'h1);
        check("write count", wr, 8'h14);
        end_sim();
    end
endmodule : dsp_alu_accumulator_shift_logic_bench
`default_nettype wire
